// ### inc/pmbus_id_defs.svh
// Command codes, field positions, reset values and lengths for the id block
`ifndef PMBUS_ID_DEFS_SVH
`define PMBUS_ID_DEFS_SVH

// Command codes
`define OFS_CLEAR_FAULTS 8'h03
`define OFS_DATE         8'h9d
`define OFS_SERIAL       8'h9e
`define OFS_PART         8'had
`define OFS_REV          8'hae
`define OFS_SCRATCH      8'hb0
`define OFS_ACTION       8'hc4

// Byte counts of each command
`define LEN_NONE    5'h00
`define LEN_DATE    5'h0c
`define LEN_SERIAL  5'h14
`define LEN_PART    5'h08
`define LEN_REV     5'h08
`define LEN_SCRATCH 5'h10
`define LEN_ACTION  5'h01

// Action register field positions
`define ACT_RESP_MSB  7
`define ACT_RESP_LSB  6
`define ACT_RETRY_MSB 5
`define ACT_RETRY_LSB 3
`define ACT_DELAY_MSB 2
`define ACT_DELAY_LSB 0

// Field codes
`define RESP_IGNORE   2'h0
`define RESP_GRACE    2'h1
`define RESP_DISABLE  2'h2
`define RESP_LATCH    2'h3
`define RETRY_NONE    3'h0
`define RETRY_ENDLESS 3'h7

// Reset values
`define ACTION_RESET  8'h00
`define SCRATCH_RESET 128'h0

`endif

// ### inc/pmbus_id_pkg.sv
// Types shared by the id and warning response block
`default_nettype none
package pmbus_id_pkg;

  // One decoded command from the bus front end
  typedef struct packed {
    logic         wr;    // Write or send-byte
    logic         rd;    // Read
    logic [7:0]   cmd;   // Command code
    logic [4:0]   len;   // Write byte count
    logic [159:0] data;  // Write data, low byte first
  } pmbus_req_s;

  // Answer to one command
  typedef struct packed {
    logic         valid;
    logic         ack;
    logic [4:0]   len;
    logic [159:0] data;
  } pmbus_rsp_s;

  // Warning action register layout
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } action_s;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_GRACE   = 2'b01,
    ST_HOLDOFF = 2'b10,
    ST_LATCHED = 2'b11
  } resp_state_e;

endpackage
`default_nettype wire

// ### hdl/pmbus_cmd_decode.sv
// Command decode and read-back mux for the id and user data commands
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_id_defs.svh"
module pmbus_cmd_decode #(
  parameter logic [95:0]  DATE_STR   = {12{8'h30}}, // Arbitrary value
  parameter logic [159:0] SERIAL_STR = {20{8'h30}}, // Arbitrary value
  parameter logic [63:0]  PART_STR   = {8{8'h41}},  // Arbitrary value
  parameter logic [63:0]  REV_STR    = {8{8'h42}}   // Arbitrary value
) (
  input  wire logic                  i_clock,    // Clock for checks only
  input  wire logic                  i_rst_b,    // Reset for checks only
  input  wire logic [7:0]            i_cmd,      // Command code
  input  wire logic [127:0]          i_scratch,  // Stored user bytes
  input  wire pmbus_id_pkg::action_s i_action,   // Stored action
  output var  logic                  o_known,    // Command exists
  output var  logic                  o_readable, // Command can be read
  output var  logic                  o_writable, // Command can be written
  output var  logic [4:0]            o_len,      // Byte count
  output var  logic [159:0]          o_rdata     // Read value
);
  import pmbus_id_pkg::*;

  // Map each command to its length, access and value
  always_comb begin
    o_known    = 1'b1;
    o_readable = 1'b1;
    o_writable = 1'b0;
    o_len      = `LEN_NONE;
    o_rdata    = 160'h0;
    case (i_cmd)
      `OFS_DATE: begin
        o_len   = `LEN_DATE;
        o_rdata = {64'h0, DATE_STR};
      end
      `OFS_SERIAL: begin
        o_len   = `LEN_SERIAL;
        o_rdata = SERIAL_STR;
      end
      `OFS_PART: begin
        o_len   = `LEN_PART;
        o_rdata = {96'h0, PART_STR};
      end
      `OFS_REV: begin
        o_len   = `LEN_REV;
        o_rdata = {96'h0, REV_STR};
      end
      `OFS_SCRATCH: begin
        o_len      = `LEN_SCRATCH;
        o_writable = 1'b1;
        o_rdata    = {32'h0, i_scratch};
      end
      `OFS_ACTION: begin
        o_len      = `LEN_ACTION;
        o_writable = 1'b1;
        o_rdata    = {152'h0, i_action};
      end
      `OFS_CLEAR_FAULTS: begin
        o_readable = 1'b0;
        o_writable = 1'b1;
      end
      default: begin
        o_known = 1'b0;
      end
    endcase
  end

  // Scratch reads reflect the stored bytes
  a_scratch_mux: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_cmd == `OFS_SCRATCH |-> o_rdata[127:0] == i_scratch && o_writable)
    else $error("scratch read-back mux wrong");

endmodule
`default_nettype wire

// ### hdl/pmbus_id_regs.sv
// Id and user data commands with the input overvoltage warning response
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_id_defs.svh"
module pmbus_id_regs #(
  parameter logic [95:0]  DATE_STR   = {12{8'h30}}, // Arbitrary value
  parameter logic [159:0] SERIAL_STR = {20{8'h30}}, // Arbitrary value
  parameter logic [63:0]  PART_STR   = {8{8'h41}},  // Arbitrary value
  parameter logic [63:0]  REV_STR    = {8{8'h42}}   // Arbitrary value
) (
  input  wire logic                     i_clock,          // 100 MHz clock
  input  wire logic                     i_rst_b,          // Sync reset, low
  input  wire pmbus_id_pkg::pmbus_req_s i_req,            // Command request
  output var  pmbus_id_pkg::pmbus_rsp_s o_rsp,            // Command answer
  input  wire logic [15:0]              i_unit_cycles,    // Cycles per unit
  input  wire logic                     i_warn,           // Warning level
  input  wire logic                     i_output_on_cmd,  // Output wanted
  input  wire logic                     i_clear_warn_bit, // Status bit clear
  input  wire logic                     i_other_shutdown, // Other fault off
  output var  logic                     o_output_enable,  // Output allowed
  output var  logic                     o_warn_status,    // Sticky warning
  output var  pmbus_id_pkg::resp_state_e o_resp_state     // Response state
);
  import pmbus_id_pkg::*;

  logic          known;
  logic          readable;
  logic          writable;
  logic [4:0]    want_len;
  logic [159:0]  rdata;
  logic          rd_ok;
  logic          wr_ok;
  logic          clear_faults;
  logic [127:0]  scratch_ff;
  action_s       action_ff;
  pmbus_rsp_s    rsp_ff;
  logic          warn_d_ff;
  logic          cmd_d_ff;
  logic          warn_rise;
  logic          cmd_rise;
  logic          cmd_fall;
  logic [15:0]   unit_eff;
  logic [22:0]   total_m1;
  resp_state_e   state_ff;
  resp_state_e   nxt_state;
  logic [22:0]   timer_ff;
  logic [22:0]   nxt_timer;
  logic [2:0]    tries_ff;
  logic [2:0]    nxt_tries;
  logic          enable_ff;
  logic          status_ff;

  // Command decode and read values
  pmbus_cmd_decode #(
    .DATE_STR   (DATE_STR),
    .SERIAL_STR (SERIAL_STR),
    .PART_STR   (PART_STR),
    .REV_STR    (REV_STR)
  ) u_decode (
    .i_clock    (i_clock),
    .i_rst_b    (i_rst_b),
    .i_cmd      (i_req.cmd),
    .i_scratch  (scratch_ff),
    .i_action   (action_ff),
    .o_known    (known),
    .o_readable (readable),
    .o_writable (writable),
    .o_len      (want_len),
    .o_rdata    (rdata)
  );

  // Accept checks; a write must carry the exact byte count
  assign rd_ok = i_req.rd & known & readable;
  assign wr_ok = i_req.wr & known & writable & (i_req.len == want_len);
  assign clear_faults = wr_ok & (i_req.cmd == `OFS_CLEAR_FAULTS);

  // Scratch storage
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      scratch_ff <= `SCRATCH_RESET;
    end else if (wr_ok && i_req.cmd == `OFS_SCRATCH) begin
      scratch_ff <= i_req.data[127:0];
    end
  end

  // Warning action register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      action_ff <= `ACTION_RESET;
    end else if (wr_ok && i_req.cmd == `OFS_ACTION) begin
      action_ff <= i_req.data[7:0];
    end
  end

  // Answer one cycle after each request; writes win over reads
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= i_req.rd | i_req.wr;
      rsp_ff.ack   <= i_req.wr ? wr_ok : rd_ok;
      rsp_ff.len   <= (!i_req.wr && rd_ok) ? want_len : `LEN_NONE;
      rsp_ff.data  <= (!i_req.wr && rd_ok) ? rdata : 160'h0;
    end
  end
  assign o_rsp = rsp_ff;

  // Edge detectors on same-clock inputs
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      warn_d_ff <= 1'b0;
      cmd_d_ff  <= 1'b0;
    end else begin
      warn_d_ff <= i_warn;
      cmd_d_ff  <= i_output_on_cmd;
    end
  end
  assign warn_rise = i_warn & ~warn_d_ff;
  assign cmd_rise  = i_output_on_cmd & ~cmd_d_ff;
  assign cmd_fall  = ~i_output_on_cmd & cmd_d_ff;

  // Delay length: unit from the timing setting, scaled by two to the code
  assign unit_eff = (i_unit_cycles == 16'h0) ? 16'h1 : i_unit_cycles;
  assign total_m1 = 23'(({7'h0, unit_eff} << action_ff.delay) - 23'd1);

  // Response sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_tries = tries_ff;
    nxt_timer = (timer_ff != 23'h0) ? 23'(timer_ff - 23'd1) : timer_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (warn_rise) begin
          unique case (action_ff.resp)
            `RESP_IGNORE: begin
              nxt_state = ST_RUN;
            end
            `RESP_GRACE: begin
              nxt_state = ST_GRACE;
              nxt_timer = total_m1;
            end
            `RESP_DISABLE: begin
              nxt_tries = 3'h0;
              nxt_timer = total_m1;
              nxt_state = (action_ff.retry == `RETRY_NONE) ?
                          ST_LATCHED : ST_HOLDOFF;
            end
            `RESP_LATCH: begin
              nxt_state = ST_LATCHED;
            end
          endcase
        end
      end
      ST_GRACE: begin
        if (cmd_fall) begin
          nxt_state = ST_RUN;
        end else if (timer_ff == 23'h0) begin
          nxt_tries = 3'h0;
          nxt_timer = total_m1;
          if (!i_warn) begin
            nxt_state = ST_RUN;
          end else begin
            nxt_state = (action_ff.retry == `RETRY_NONE) ?
                        ST_LATCHED : ST_HOLDOFF;
          end
        end
      end
      ST_HOLDOFF: begin
        if (cmd_fall || i_other_shutdown) begin
          nxt_state = ST_RUN;
        end else if (timer_ff == 23'h0) begin
          if (!i_warn) begin
            nxt_state = ST_RUN;
          end else if (action_ff.retry == `RETRY_ENDLESS ||
                       3'(tries_ff + 3'd1) < action_ff.retry) begin
            nxt_tries = 3'(tries_ff + 3'd1);
            nxt_timer = total_m1;
          end else begin
            nxt_state = ST_LATCHED;
          end
        end
      end
      ST_LATCHED: begin
        if (clear_faults || i_clear_warn_bit || cmd_rise) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_ff <= ST_RUN;
      timer_ff <= 23'h0;
      tries_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      tries_ff <= nxt_tries;
    end
  end

  // Output allowed only while running or in the grace delay
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      enable_ff <= 1'b0;
    end else begin
      enable_ff <= i_output_on_cmd &
                   (nxt_state == ST_RUN || nxt_state == ST_GRACE);
    end
  end

  // Sticky warning flag; a new warning wins over a clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      status_ff <= 1'b0;
    end else if (warn_rise) begin
      status_ff <= 1'b1;
    end else if (clear_faults || i_clear_warn_bit) begin
      status_ff <= 1'b0;
    end
  end

  assign o_output_enable = enable_ff;
  assign o_warn_status   = status_ff;
  assign o_resp_state    = state_ff;

  a_ignore_keeps_on: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_RUN && warn_rise && action_ff.resp == `RESP_IGNORE &&
    i_output_on_cmd |=> o_output_enable && state_ff == ST_RUN)
    else $error("ignore response interrupted output");

  a_grace_then_run: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_GRACE && timer_ff == 23'h0 && !i_warn && !cmd_fall
    |=> state_ff == ST_RUN)
    else $error("grace delay did not return to run");

  a_disable_now: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_RUN && warn_rise && action_ff.resp == `RESP_DISABLE
    |=> !o_output_enable)
    else $error("disable response left output on");

  a_latch_holds: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_LATCHED && !clear_faults && !i_clear_warn_bit && !cmd_rise
    |=> state_ff == ST_LATCHED && !o_output_enable)
    else $error("latched fault released without clear");

  a_onoff_clears: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_LATCHED && i_output_on_cmd && !cmd_d_ff
    |=> state_ff == ST_RUN ##1 o_output_enable || !i_output_on_cmd)
    else $error("off-on command did not clear latch");

  a_no_retry: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_RUN && warn_rise && action_ff.resp == `RESP_DISABLE &&
    action_ff.retry == `RETRY_NONE |=> state_ff == ST_LATCHED)
    else $error("zero retry did not latch off");

  a_tries_used: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_HOLDOFF && timer_ff == 23'h0 && i_warn && !cmd_fall &&
    !i_other_shutdown && action_ff.retry != `RETRY_ENDLESS &&
    3'(tries_ff + 3'd1) >= action_ff.retry |=> state_ff == ST_LATCHED)
    else $error("retry limit not enforced");

  a_spacing_load: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_HOLDOFF && nxt_state == ST_HOLDOFF && timer_ff == 23'h0
    |=> timer_ff == $past(total_m1))
    else $error("restart spacing not reloaded");

  a_date_read: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_req.rd && !i_req.wr && i_req.cmd == `OFS_DATE
    |=> o_rsp.ack && o_rsp.len == `LEN_DATE && o_rsp.data[95:0] == DATE_STR)
    else $error("date read wrong");

  a_serial_read: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_req.rd && !i_req.wr && i_req.cmd == `OFS_SERIAL
    |=> o_rsp.ack && o_rsp.len == `LEN_SERIAL && o_rsp.data == SERIAL_STR)
    else $error("serial read wrong");

  a_scratch_store: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_req.wr && i_req.cmd == `OFS_SCRATCH && i_req.len == `LEN_SCRATCH
    |=> o_rsp.ack && scratch_ff == $past(i_req.data[127:0]))
    else $error("scratch write lost");

  a_endless_retry: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_HOLDOFF && action_ff.retry == `RETRY_ENDLESS && i_warn &&
    !cmd_fall && !i_other_shutdown |=> state_ff == ST_HOLDOFF)
    else $error("endless retry stopped");

  a_delay_scale: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_unit_cycles == 16'h1 && action_ff.delay == 3'h7 |-> total_m1 == 23'd127)
    else $error("delay code scaling wrong");

  a_part_read: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_req.rd && !i_req.wr && i_req.cmd == `OFS_PART
    |=> o_rsp.ack && o_rsp.len == `LEN_PART && o_rsp.data[63:0] == PART_STR)
    else $error("part read wrong");

endmodule
`default_nettype wire

// ### verification/pmbus_host_model.sv
// Host model that issues one command at a time on the request port
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input  wire logic                     i_clock, // Bus clock
  output var  pmbus_id_pkg::pmbus_req_s o_req,   // Request to device
  input  wire pmbus_id_pkg::pmbus_rsp_s i_rsp    // Answer from device
);
  import pmbus_id_pkg::*;

  // Idle bus until the first command
  initial begin
    o_req = '0;
  end

  // Present a command for one edge, then take the answer one edge later;
  // released strobes drop to zero and the other fields carry inverted values so stale data never looks valid
  task automatic xfer(input logic wr, input logic rd, input logic [7:0] cmd,
                      input logic [4:0] len, input logic [159:0] data,
                      output pmbus_rsp_s rsp);
    @(posedge i_clock);
    o_req <= '{wr: wr, rd: rd, cmd: cmd, len: len, data: data};
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, len: ~len, data: ~data};
    @(posedge i_clock);
    rsp = i_rsp;
  endtask
endmodule
`default_nettype wire

// ### verification/pmbus_id_and_vin_ov_warn_response_tb.sv
// Self-checking bench for the id commands and warning response
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_id_defs.svh"
module pmbus_id_and_vin_ov_warn_response_tb;
  import pmbus_id_pkg::*;
  localparam logic [95:0]  DATE = {12{8'h44}}; // Arbitrary text
  localparam logic [159:0] SER  = {20{8'h53}}; // Arbitrary text
  localparam logic [63:0]  PART = {8{8'h50}};  // Arbitrary text
  localparam logic [63:0]  REV  = {8{8'h52}};  // Arbitrary text
  // Read-only commands that must refuse a write
  localparam logic [7:0]   RO_CMD [4] = '{`OFS_DATE, `OFS_SERIAL,
                                          `OFS_PART, `OFS_REV};
  logic        clock, rst_b, warn, on_cmd, clr_bit, other_sd, out_en, wst;
  logic [15:0] unit, u;
  pmbus_req_s  req;
  pmbus_rsp_s  rsp, rsp_seen;
  resp_state_e state;
  int          fails, num_checks, cycles, n1, n2;
  logic [127:0] sd;

  pmbus_id_regs #(.DATE_STR(DATE), .SERIAL_STR(SER), .PART_STR(PART),
                  .REV_STR(REV)) i_dut (
    .i_clock(clock), .i_rst_b(rst_b), .i_req(req), .o_rsp(rsp),
    .i_unit_cycles(unit), .i_warn(warn), .i_output_on_cmd(on_cmd),
    .i_clear_warn_bit(clr_bit), .i_other_shutdown(other_sd),
    .o_output_enable(out_en), .o_warn_status(wst), .o_resp_state(state));

  pmbus_host_model i_host (.i_clock(clock), .o_req(req), .i_rsp(rsp));

  // 100 MHz clock
  always #5 clock = ~clock;

  // Cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      final_report();
    end
  end

  // Delay length in cycles for a unit count and delay code
  function automatic int exp_delay(input logic [15:0] uc, input logic [2:0] d);
    return ((uc == 16'h0) ? 1 : int'(uc)) << d;
  endfunction

  // Compare and count
  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic wr, input logic rd, input logic [7:0] c,
                     input logic [4:0] n, input logic [159:0] d);
    i_host.xfer(wr, rd, c, n, d, rsp_seen);
  endtask

  // Read and compare acknowledge, length and data
  task automatic rd_chk(input logic [7:0] c, input logic [4:0] n,
                        input logic [159:0] exp);
    cmd(1'b0, 1'b1, c, 5'h00, '0);
    check(rsp_seen.valid, 1'b1);
    check(rsp_seen.ack, 1'b1);
    check(rsp_seen.len, n);
    check(rsp_seen.data, exp);
  endtask

  // Program the action byte, then raise the warning
  task automatic arm(input logic [1:0] r, input logic [2:0] t,
                     input logic [2:0] d);
    cmd(1'b1, 1'b0, `OFS_ACTION, 5'h01, {152'h0, r, t, d});
    check(rsp_seen.ack, 1'b1);
    @(posedge clock) warn <= 1'b1;
  endtask

  // Drop the warning, clear faults and wait for normal running
  task automatic settle();
    int k;
    @(posedge clock) warn <= 1'b0;
    cmd(1'b1, 1'b0, `OFS_CLEAR_FAULTS, 5'h00, '0);
    check(rsp_seen.ack, 1'b1);
    k = 0;
    while (state !== ST_RUN && k < 1100) begin
      @(posedge clock);
      k++;
    end
    check(state, ST_RUN);
    check(wst, 1'b0);
  endtask

  // Cycles from warning rise to latched off
  task automatic meas(input logic [1:0] r, input logic [2:0] t,
                      input logic [2:0] d, output int n);
    arm(r, t, d);
    n = 0;
    while (state !== ST_LATCHED && n < 3000) begin
      @(posedge clock);
      n++;
    end
    settle();
  endtask

  // Main sequence
  initial begin
    clock = 1'b0; rst_b = 1'b0; warn = 1'b0; on_cmd = 1'b1; clr_bit = 1'b0;
    other_sd = 1'b0; unit = 16'h1; fails = 0; num_checks = 0; cycles = 0;
    void'($urandom(38536));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    rd_chk(`OFS_ACTION, 5'h01, '0);
    rd_chk(`OFS_SCRATCH, 5'h10, '0);
    rd_chk(`OFS_DATE, 5'h0c, {64'h0, DATE});
    rd_chk(`OFS_SERIAL, 5'h14, SER);
    rd_chk(`OFS_PART, 5'h08, {96'h0, PART});
    rd_chk(`OFS_REV, 5'h08, {96'h0, REV});
    for (int i = 0; i < 4; i++) begin
      cmd(1'b1, 1'b0, RO_CMD[i], 5'h08, '1);
      check(rsp_seen.ack, 1'b0);
    end
    cmd(1'b0, 1'b1, 8'hb1, 5'h00, '0);
    check(rsp_seen.ack, 1'b0);
    cmd(1'b0, 1'b1, `OFS_CLEAR_FAULTS, 5'h00, '0);
    check(rsp_seen.ack, 1'b0);
    // Scratch write and read back, then a short write that must not land
    repeat (4) begin
      sd = {$urandom, $urandom, $urandom, $urandom};
      cmd(1'b1, 1'b0, `OFS_SCRATCH, 5'h10, {32'h0, sd});
      rd_chk(`OFS_SCRATCH, 5'h10, {32'h0, sd});
    end
    cmd(1'b1, 1'b0, `OFS_SCRATCH, 5'h0f, '1);
    check(rsp_seen.ack, 1'b0);
    rd_chk(`OFS_SCRATCH, 5'h10, {32'h0, sd});
    // Ignore; a status clear at the rise edge loses to the new warning
    @(posedge clock) clr_bit <= 1'b1;
    arm(2'h0, 3'h2, 3'h0);
    @(posedge clock) clr_bit <= 1'b0;
    repeat (20) @(posedge clock);
    check({out_en, state}, {1'b1, ST_RUN});
    check(wst, 1'b1);
    settle();
    // Latch off, cleared by status bit, by on/off and by clear-faults
    arm(2'h3, 3'h0, 3'h0);
    repeat (12) @(posedge clock);
    check({out_en, state}, {1'b0, ST_LATCHED});
    warn <= 1'b0;
    @(posedge clock) clr_bit <= 1'b1;
    @(posedge clock) clr_bit <= 1'b0;
    @(posedge clock);
    check(state, ST_RUN);
    arm(2'h3, 3'h0, 3'h0);
    @(posedge clock) on_cmd <= 1'b0;
    @(posedge clock) on_cmd <= 1'b1;
    repeat (2) @(posedge clock);
    check({out_en, state}, {1'b1, ST_RUN});
    @(posedge clock) warn <= 1'b0;
    arm(2'h3, 3'h0, 3'h0);
    repeat (2) @(posedge clock);
    check(state, ST_LATCHED);
    cmd(1'b1, 1'b0, `OFS_CLEAR_FAULTS, 5'h00, '0);
    check(rsp_seen.ack, 1'b1);
    repeat (5) @(posedge clock);
    check(state, ST_RUN);
    settle();
    // Disable without retry
    arm(2'h2, 3'h0, 3'h0);
    repeat (2) @(posedge clock);
    check(out_en, 1'b0);
    repeat (20) @(posedge clock);
    check({out_en, state}, {1'b0, ST_LATCHED});
    settle();
    // Restart spacing over every delay code with a random unit length
    for (int d = 0; d < 8; d++) begin
      u = 16'($urandom % 4);
      @(posedge clock) unit <= u;
      meas(2'h2, 3'h1, 3'(d), n1);
      meas(2'h2, 3'h2, 3'(d), n2);
      check(160'(n2 - n1), 160'(exp_delay(u, 3'(d))));
    end
    // Retry counts two to six, one delay apart each
    @(posedge clock) unit <= 16'h2;
    meas(2'h2, 3'h1, 3'h1, n1);
    for (int r = 2; r < 7; r++) begin
      meas(2'h2, 3'(r), 3'h1, n2);
      check(160'(n2 - n1), 160'((r - 1) * 4));
    end
    // Endless retry, stopped by output off, then by another fault
    arm(2'h2, 3'h7, 3'h0);
    n1 = 0;
    repeat (200) begin
      @(posedge clock);
      if (state === ST_LATCHED) n1++;
    end
    check(160'(n1), 160'h0);
    @(posedge clock) on_cmd <= 1'b0;
    repeat (2) @(posedge clock);
    check(state, ST_RUN);
    on_cmd <= 1'b1;
    @(posedge clock) warn <= 1'b0;
    arm(2'h2, 3'h7, 3'h0);
    repeat (5) @(posedge clock);
    other_sd <= 1'b1;
    @(posedge clock) other_sd <= 1'b0;
    @(posedge clock);
    check(state, ST_RUN);
    settle();
    // Successful restart when the warning goes away
    arm(2'h2, 3'h3, 3'h2);
    repeat (3) @(posedge clock);
    warn <= 1'b0;
    repeat (20) @(posedge clock);
    check({out_en, state}, {1'b1, ST_RUN});
    // Grace period keeps running, then disables while the warning stays
    arm(2'h1, 3'h0, 3'h3);
    repeat (2) @(posedge clock);
    check({out_en, state}, {1'b1, ST_GRACE});
    repeat (10) @(posedge clock);
    check(out_en, 1'b1);
    repeat (12) @(posedge clock);
    check(out_en, 1'b0);
    settle();
    arm(2'h1, 3'h0, 3'h3);
    repeat (5) @(posedge clock);
    warn <= 1'b0;
    repeat (30) @(posedge clock);
    check({out_en, state}, {1'b1, ST_RUN});
    // Mid-run reset releases a latch and restores the registers
    arm(2'h3, 3'h0, 3'h0);
    repeat (2) @(posedge clock);
    check(state, ST_LATCHED);
    rst_b <= 1'b0;
    warn <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    check({out_en, state, wst}, {1'b1, ST_RUN, 1'b0});
    rd_chk(`OFS_ACTION, 5'h01, '0);
    rd_chk(`OFS_SCRATCH, 5'h10, '0);
    final_report();
  end
endmodule
`default_nettype wire
